// *** aff_ctrl.sv ***
`timescale 1ns/1ns
module aff_ctrl
  import aff_pkg::*;
(
  input wire logic CORE_CLK, // 50 MHz clock
  input wire logic SRST, // sync reset, active high
  input wire logic HSEL, // ahb select
  input wire logic [31:0] HADDR, // ahb address
  input wire logic [1:0] HTRANS, // ahb transfer type
  input wire logic HWRITE, // ahb direction
  input wire logic [2:0] HSIZE, // ahb size
  input wire logic [31:0] HWDATA, // ahb write data
  input wire logic HREADY, // ahb bus ready
  output logic [31:0] HRDATA, // ahb read data
  output logic HREADYOUT, // ahb slave ready
  output logic HRESP, // ahb response, always okay
  output logic WR_STROBE_N, // device write strobe
  output logic RD_STROBE_N, // device read strobe
  output logic INIT_N, // device reset
  output logic REPLAY_N, // retransmit / first-load pin
  output logic CHAIN_TOKEN_IN_N, // chain input pin drive
  output logic [aff_pkg::AFF_DW-1:0] DATA_IN, // data to device
  input wire logic [aff_pkg::AFF_DW-1:0] DATA_OUT, // data from device
  input wire logic NO_ROOM_N, // full flag
  input wire logic NO_WORDS_N, // empty flag
  input wire logic MIDPOINT_FLAG_N // half-full / chain out
);
  import aff_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [AFF_DW+2:0] pins_s;
  // chained or width-grouped devices: the flag pins carry the combined flags of the group
  aff_sync #(.W(AFF_DW + 3)) u_sync (
    .clk(CORE_CLK),
    .srst(SRST),
    .d({DATA_OUT, NO_ROOM_N, NO_WORDS_N, MIDPOINT_FLAG_N}),
    .q(pins_s)
  );
  logic full_n;
  logic empty_n;
  logic half_n;
  logic [AFF_DW-1:0] dout_s;
  assign full_n = pins_s[2];
  assign empty_n = pins_s[1];
  assign half_n = pins_s[0];
  assign dout_s = pins_s[AFF_DW+2:3];

  // ---------------------------------------------------------------
  // ahb-lite slave
  // ---------------------------------------------------------------
  logic dp_wr;
  logic [7:0] dp_addr;
  logic [31:0] ctrl;
  logic [AFF_DW-1:0] wdata;
  logic [AFF_DW-1:0] rdata;
  logic refused;
  logic rvalid;
  logic [2:0] cmd;
  logic cmd_pend;
  aff_state_t state;
  logic [7:0] cnt;
  logic next_dp_wr;
  logic [7:0] next_dp_addr;
  logic [31:0] next_ctrl;
  logic [AFF_DW-1:0] next_wdata;
  logic [AFF_DW-1:0] next_rdata;
  logic next_refused;
  logic next_rvalid;
  logic [2:0] next_cmd;
  logic next_cmd_pend;
  logic [31:0] next_hrdata;
  logic busy;
  logic done_cmd;
  logic take_rdata;
  logic refuse_now;

  assign busy = cmd_pend || (state != AFF_IDLE);

  always_comb begin
    next_dp_wr = 1'b0;
    next_dp_addr = dp_addr;
    next_ctrl = ctrl;
    next_wdata = wdata;
    next_rdata = take_rdata ? dout_s : rdata;
    // a refusal seen in the same cycle as a status read still sticks
    next_refused = refused;
    next_rvalid = rvalid || take_rdata;
    next_cmd = cmd;
    next_cmd_pend = cmd_pend && !done_cmd;
    next_hrdata = HRDATA;
    // read data are chosen in the address phase so that they stand during the data phase
    if (HSEL && HREADY && HTRANS[1]) begin
      next_dp_wr = HWRITE;
      next_dp_addr = HADDR[7:0];
      if (!HWRITE) begin
        unique case (HADDR[7:0])
          AFF_CTRL_OFS: next_hrdata = ctrl;
          AFF_WDATA_OFS: next_hrdata = {23'h000000, wdata};
          AFF_RDATA_OFS: next_hrdata = {23'h000000, rdata};
          AFF_STAT_OFS: begin
            next_hrdata = {26'h0000000, rvalid, refused, !half_n, !full_n, !empty_n, busy};
            next_refused = 1'b0;
          end
          default: next_hrdata = 32'h00000000;
        endcase
        if (HADDR[7:0] == AFF_RDATA_OFS) begin
          next_rvalid = 1'b0;
        end
      end
    end
    if (dp_wr) begin
      unique case (dp_addr)
        AFF_CTRL_OFS: next_ctrl = HWDATA;
        AFF_WDATA_OFS: next_wdata = HWDATA[AFF_DW-1:0];
        AFF_CMD_OFS: begin
          if (!busy) begin
            next_cmd = HWDATA[2:0];
            next_cmd_pend = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (refuse_now) begin
      next_refused = 1'b1;
    end
    if (take_rdata) begin
      next_rvalid = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      dp_wr <= 1'b0;
      dp_addr <= 8'h00;
      ctrl <= AFF_CTRL_RST;
      wdata <= '0;
      rdata <= '0;
      refused <= 1'b0;
      rvalid <= 1'b0;
      cmd <= 3'h0;
      cmd_pend <= 1'b0;
      HRDATA <= 32'h00000000;
    end else begin
      dp_wr <= next_dp_wr;
      dp_addr <= next_dp_addr;
      ctrl <= next_ctrl;
      wdata <= next_wdata;
      rdata <= next_rdata;
      refused <= next_refused;
      rvalid <= next_rvalid;
      cmd <= next_cmd;
      cmd_pend <= next_cmd_pend;
      HRDATA <= next_hrdata;
    end
  end

  // ---------------------------------------------------------------
  // strobe sequencer
  // ---------------------------------------------------------------
  aff_state_t next_state;
  logic [7:0] next_cnt;
  logic next_wr_n;
  logic next_rd_n;
  logic next_init_n;
  logic next_replay_n;
  logic next_chain_n;
  logic [AFF_DW-1:0] next_din;
  logic chained;

  assign chained = ctrl[AFF_CTRL_CHAIN_BIT];

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_wr_n = WR_STROBE_N;
    next_rd_n = RD_STROBE_N;
    next_init_n = INIT_N;
    next_replay_n = REPLAY_N;
    // single device: ground the chain input; chained: drive it high from this controller
    next_chain_n = chained;
    next_din = DATA_IN;
    done_cmd = 1'b0;
    take_rdata = 1'b0;
    refuse_now = 1'b0;
    // first-load level when chained and not replaying
    if (chained && state == AFF_IDLE) begin
      next_replay_n = !ctrl[AFF_CTRL_LEAD_BIT];
    end
    unique case (state)
      AFF_IDLE: begin
        if (cmd_pend) begin
          done_cmd = 1'b1;
          next_cnt = AFF_PULSE_CYC;
          unique case (cmd)
            AFF_CMD_WRITE: begin
              // strobe only while not full, so the device pointer moves
              if (full_n) begin
                next_din = wdata;
                next_wr_n = 1'b0;
                next_state = AFF_ACT;
              end else begin
                refuse_now = 1'b1;
              end
            end
            AFF_CMD_READ: begin
              if (empty_n) begin
                next_rd_n = 1'b0;
                next_state = AFF_ACT;
              end else begin
                refuse_now = 1'b1;
              end
            end
            AFF_CMD_INIT: begin
              // strobes are idle high here, so they stand high around the pulse
              next_init_n = 1'b0;
              next_cnt = AFF_INIT_CYC;
              next_state = AFF_ACT;
            end
            AFF_CMD_REPLAY: begin
              // replay does not exist on a chained device
              if (!chained) begin
                next_replay_n = 1'b0;
                next_state = AFF_ACT;
              end else begin
                refuse_now = 1'b1;
              end
            end
            default: refuse_now = 1'b1;
          endcase
        end
      end
      AFF_WAIT: next_state = AFF_IDLE;
      AFF_ACT: begin
        if (cnt > 8'h01) begin
          next_cnt = cnt - 8'h01;
        end else begin
          // data is sampled before rd rises: the bus floats once rd is high
          if (!RD_STROBE_N) begin
            take_rdata = 1'b1;
          end
          // the device stores the word on this rising edge of wr
          next_wr_n = 1'b1;
          next_rd_n = 1'b1;
          next_init_n = 1'b1;
          next_replay_n = chained ? !ctrl[AFF_CTRL_LEAD_BIT] : 1'b1;
          next_cnt = AFF_RECOV_CYC;
          next_state = AFF_RECOV;
        end
      end
      AFF_RECOV: begin
        // recovery also lets the synchronised flags settle before the next check
        if (cnt > 8'h01) begin
          next_cnt = cnt - 8'h01;
        end else begin
          next_state = AFF_WAIT;
        end
      end
      default: next_state = AFF_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      state <= AFF_IDLE;
      cnt <= 8'h00;
      WR_STROBE_N <= 1'b1;
      RD_STROBE_N <= 1'b1;
      INIT_N <= 1'b1;
      REPLAY_N <= 1'b1;
      CHAIN_TOKEN_IN_N <= 1'b0;
      DATA_IN <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      WR_STROBE_N <= next_wr_n;
      RD_STROBE_N <= next_rd_n;
      INIT_N <= next_init_n;
      REPLAY_N <= next_replay_n;
      CHAIN_TOKEN_IN_N <= next_chain_n;
      DATA_IN <= next_din;
    end
  end

  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_wr_fall;
    $fell(WR_STROBE_N);
  endsequence
  sequence s_wr_held;
    !WR_STROBE_N [*3];
  endsequence
  a_write_when_room: assert property (@(posedge CORE_CLK) disable iff (SRST)
    $fell(WR_STROBE_N) |-> $past(full_n)) else $error("write strobe while full");
  a_read_when_words: assert property (@(posedge CORE_CLK) disable iff (SRST)
    $fell(RD_STROBE_N) |-> $past(empty_n)) else $error("read strobe while empty");
  a_write_pulse_len: assert property (@(posedge CORE_CLK) disable iff (SRST)
    s_wr_fall |-> s_wr_held ##1 WR_STROBE_N) else $error("write pulse width wrong");
  a_strobes_in_init: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !INIT_N |-> WR_STROBE_N && RD_STROBE_N) else $error("strobe low during init");
  a_strobes_in_replay: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !REPLAY_N && !chained |-> WR_STROBE_N && RD_STROBE_N) else $error("strobe low during replay");
  a_no_chain_replay: assert property (@(posedge CORE_CLK) disable iff (SRST)
    chained && state == AFF_ACT |-> $stable(REPLAY_N)) else $error("replay pulsed while chained");
  a_chain_pin_mode: assert property (@(posedge CORE_CLK) disable iff (SRST)
    ##1 CHAIN_TOKEN_IN_N == $past(chained)) else $error("chain input level wrong");
  a_init_len: assert property (@(posedge CORE_CLK) disable iff (SRST)
    $fell(INIT_N) |-> !INIT_N [*8] ##[1:3] INIT_N) else $error("init pulse length wrong");
  a_read_capture: assert property (@(posedge CORE_CLK) disable iff (SRST)
    $rose(RD_STROBE_N) |=> rvalid) else $error("read data not captured");
endmodule // aff_ctrl

// *** aff_pkg.sv ***
package aff_pkg;
  // ---------------------------------------------------------------
  // register map of the controller (own registers, AHB-Lite words)
  // ---------------------------------------------------------------
  localparam logic [7:0] AFF_CTRL_OFS = 8'h00;
  localparam logic [7:0] AFF_WDATA_OFS = 8'h04;
  localparam logic [7:0] AFF_RDATA_OFS = 8'h08;
  localparam logic [7:0] AFF_STAT_OFS = 8'h0C;
  localparam logic [7:0] AFF_CMD_OFS = 8'h10;
  // ctrl bits
  localparam int AFF_CTRL_LEAD_BIT = 0;
  localparam int AFF_CTRL_CHAIN_BIT = 1;
  // cmd codes written to AFF_CMD_OFS
  localparam logic [2:0] AFF_CMD_WRITE = 3'h1;
  localparam logic [2:0] AFF_CMD_READ = 3'h2;
  localparam logic [2:0] AFF_CMD_INIT = 3'h3;
  localparam logic [2:0] AFF_CMD_REPLAY = 3'h4;
  // status bits
  localparam int AFF_STAT_BUSY_BIT = 0;
  localparam int AFF_STAT_EMPTY_BIT = 1;
  localparam int AFF_STAT_FULL_BIT = 2;
  localparam int AFF_STAT_HALF_BIT = 3;
  localparam int AFF_STAT_REFUSED_BIT = 4;
  localparam int AFF_STAT_RVALID_BIT = 5;
  localparam logic [31:0] AFF_CTRL_RST = 32'h00000000;
  localparam int AFF_DW = 9;
  // ---------------------------------------------------------------
  // strobe timing at 50 MHz
  // ---------------------------------------------------------------
  localparam int AFF_CLK_NS = 20;
  localparam int AFF_PULSE_NS = 60;
  localparam int AFF_RECOV_NS = 40;
  localparam int AFF_INIT_NS = 200;
  localparam logic [7:0] AFF_PULSE_CYC = 8'((AFF_PULSE_NS + AFF_CLK_NS - 1) / AFF_CLK_NS);
  localparam logic [7:0] AFF_RECOV_CYC = 8'((AFF_RECOV_NS + AFF_CLK_NS - 1) / AFF_CLK_NS);
  localparam logic [7:0] AFF_INIT_CYC = 8'((AFF_INIT_NS + AFF_CLK_NS - 1) / AFF_CLK_NS);
  typedef enum logic [2:0] {
    AFF_IDLE = 3'b000,
    AFF_WAIT = 3'b001,
    AFF_ACT = 3'b010,
    AFF_RECOV = 3'b011
  } aff_state_t;
endpackage

// *** aff_sync.sv ***
`timescale 1ns/1ns
// two-flop synchroniser for the device's flag pins and data bus
module aff_sync #(parameter int W = 1) (
  input wire logic clk, // clock
  input wire logic srst, // sync reset
  input wire logic [W-1:0] d, // async input
  output logic [W-1:0] q // synchronised
);
  logic [W-1:0] s1;
  logic [W-1:0] next_s1;
  logic [W-1:0] next_q;
  always_comb begin
    next_s1 = d;
    next_q = s1;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      s1 <= '1;
      q <= '1;
    end else begin
      s1 <= next_s1;
      q <= next_q;
    end
  end
endmodule // aff_sync

// *** aff_fifo_model.sv ***
`timescale 1ns/1ns
// ---------------------------------------------------------------
// behavioural far device: ring of DEPTH 9-bit words
// ---------------------------------------------------------------
module aff_fifo_model #(parameter int DEPTH = 8) (
  input wire logic w_n, // write strobe
  input wire logic r_n, // read strobe
  input wire logic init_n, // reset
  input wire logic replay_n, // retransmit / first-load
  input wire logic chain_in_n, // chain input
  input wire logic [8:0] d, // data in
  output logic [8:0] q, // data out
  output logic full_n, // full flag
  output logic empty_n, // empty flag
  output logic half_n // half-full / chain out
);
  logic [8:0] mem [DEPTH];
  int wp = 0;
  int rp = 0;
  int cnt = 0;
  logic w_ok = 1'b0;
  logic r_ok = 1'b0;
  logic half = 1'b1;
  logic xo = 1'b1;
  initial q = 9'h0A5;
  assign full_n = (cnt != DEPTH);
  assign empty_n = (cnt != 0);
  assign half_n = chain_in_n ? xo : half;
  always @(negedge init_n) begin
    wp = 0;
    rp = 0;
    cnt = 0;
    half = 1'b1;
  end
  always @(negedge w_n) begin
    w_ok = full_n && init_n;
    if (w_ok && cnt >= DEPTH / 2) half = 1'b0;
  end
  always @(posedge w_n) begin
    if (w_ok) begin
      mem[wp] = d;
      wp = (wp + 1) % DEPTH;
      cnt = cnt + 1;
      // token leaves only when the last location has been used
      if (chain_in_n && wp == 0) begin
        xo = 1'b0;
        xo <= #20 1'b1;
      end
      // read held low on an empty ring: the new word flows straight out
      if (!r_n && !r_ok && init_n && cnt == 1) begin
        r_ok = 1'b1;
        q = mem[rp];
      end
    end
    w_ok = 1'b0;
  end
  always @(negedge r_n) begin
    r_ok = empty_n && init_n;
    if (r_ok) q = mem[rp];
  end
  always @(posedge r_n) begin
    if (r_ok) begin
      rp = (rp + 1) % DEPTH;
      cnt = cnt - 1;
      if (cnt <= DEPTH / 2) half = 1'b1;
    end
    r_ok = 1'b0;
    // released bus: show the inverse so stale data never looks valid
    q = ~q;
  end
  // acting on the rise avoids a race with the chain pin changing
  always @(posedge replay_n) begin
    if (!chain_in_n && init_n) begin
      rp = 0;
      cnt = wp;
      half = (cnt <= DEPTH / 2);
    end
  end
endmodule // aff_fifo_model

// *** test_aff_ctrl.sv ***
`timescale 1ns/1ns
module test_aff_ctrl;
  import aff_pkg::*;
  localparam int DEPTH = 8;
  typedef struct {string nm; logic [31:0] e; logic [31:0] m;} aff_note_t;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  logic core_clk = 1'b0;
  logic srst, hsel, hwrite, rd_dp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, wr_n, rd_n, init_n, replay_n, chain_n, full_n, empty_n, half_n;
  logic [AFF_DW-1:0] din, dout;
  aff_note_t exp_q[$];
  aff_note_t note;
  logic [AFF_DW-1:0] sent_q[$];
  logic [AFF_DW-1:0] hist[$];
  int err_count = 0;
  int checks = 0;
  int seed = 63306;
  int cyc = 0;
  always #10 core_clk = ~core_clk;
  aff_ctrl dut_u (.CORE_CLK(core_clk), .SRST(srst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .WR_STROBE_N(wr_n), .RD_STROBE_N(rd_n), .INIT_N(init_n),
    .REPLAY_N(replay_n), .CHAIN_TOKEN_IN_N(chain_n), .DATA_IN(din), .DATA_OUT(dout),
    .NO_ROOM_N(full_n), .NO_WORDS_N(empty_n), .MIDPOINT_FLAG_N(half_n));
  aff_fifo_model #(.DEPTH(DEPTH)) far_u (.w_n(wr_n), .r_n(rd_n), .init_n(init_n), .replay_n(replay_n),
    .chain_in_n(chain_n), .d(din), .q(dout), .full_n(full_n), .empty_n(empty_n), .half_n(half_n));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic end_of_test();
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] d, input aff_note_t n);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp <= !w;
    if (!w) exp_q.push_back(n);
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd_dp <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb(a, 1'b1, d, '{"", 32'h0, 32'h0});
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m, input string nm);
    ahb(a, 1'b0, 32'h0, '{nm, e, m});
  endtask
  // fixed wait covers the longest command walk plus flag settling
  task automatic cmd(input logic [2:0] c);
    wr({24'h0, AFF_CMD_OFS}, {29'h0, c});
    repeat (30) @(posedge core_clk);
  endtask
  task automatic stat(input logic e, input logic f, input logic h, input logic r);
    rd({24'h0, AFF_STAT_OFS}, {27'h0, r, h, f, e, 1'b0}, 32'h1F, "stat");
  endtask
  task automatic put();
    int v;
    v = $random(seed);
    sent_q.push_back(v[8:0]);
    wr({24'h0, AFF_WDATA_OFS}, {23'h0, v[8:0]});
    cmd(AFF_CMD_WRITE);
  endtask
  task automatic get();
    cmd(AFF_CMD_READ);
    rd({24'h0, AFF_RDATA_OFS}, {23'h0, sent_q.pop_front()}, 32'h1FF, "rdata");
  endtask
  // ---------------------------------------------------------------
  // result watcher and timeout
  // ---------------------------------------------------------------
  always @(posedge core_clk) begin
    if (rd_dp) begin
      note = exp_q.pop_front();
      chk(note.nm, note.e & note.m, hrdata & note.m);
      chk("hresp", 32'h0, {31'h0, hresp});
    end
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    srst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    rd_dp = 1'b0;
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    rd({24'h0, AFF_CTRL_OFS}, AFF_CTRL_RST, 32'hFFFFFFFF, "ctrl");
    rd(32'h00000040, 32'h0, 32'hFFFFFFFF, "unmapped");
    cmd(AFF_CMD_INIT);
    stat(1'b1, 1'b0, 1'b0, 1'b0);
    for (int i = 0; i < DEPTH; i++) begin
      put();
      stat(1'b0, i == DEPTH - 1, i >= DEPTH / 2, 1'b0);
    end
    put();
    void'(sent_q.pop_back());
    stat(1'b0, 1'b1, 1'b1, 1'b1);
    for (int i = 0; i < DEPTH; i++) begin
      get();
      stat(i == DEPTH - 1, 1'b0, DEPTH - i - 1 > DEPTH / 2, 1'b0);
    end
    cmd(AFF_CMD_READ);
    stat(1'b1, 1'b0, 1'b0, 1'b1);
    repeat (3) put();
    hist = sent_q;
    get();
    get();
    cmd(AFF_CMD_REPLAY);
    sent_q = hist;
    repeat (3) get();
    stat(1'b1, 1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 2 * DEPTH + 1; i++) begin
      put();
      get();
    end
    wr({24'h0, AFF_CTRL_OFS}, 32'h3);
    repeat (4) @(posedge core_clk);
    chk("replay_pin", 32'h0, {31'h0, replay_n});
    chk("chain_pin", 32'h1, {31'h0, chain_n});
    cmd(AFF_CMD_INIT);
    stat(1'b1, 1'b0, 1'b0, 1'b0);
    cmd(AFF_CMD_REPLAY);
    stat(1'b1, 1'b0, 1'b0, 1'b1);
    end_of_test();
  end
endmodule // test_aff_ctrl
